// [bench/eecc_mem_model.sv]
`timescale 1ns/1ps
module eecc_mem_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    input  wire logic eecs,
    input  wire logic eesk,
    input  wire logic eedi,
    output logic      eedo,
    // Scenario controls
    input  wire logic present,
    input  wire logic slow
);
    logic [7:0]  mem [256];
    logic [18:0] sr;
    logic [18:0] nsr;
    logic [4:0]  nbits;
    logic [7:0]  rda;
    logic [2:0]  ridx;
    logic        rd;
    logic        wen;
    logic        sk_d;
    logic        cs_d;
    logic        eedo_q;
    int          prog_cnt;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        {sr, nbits, rda, ridx, rd, wen, sk_d, cs_d, eedo_q} = '0;
        prog_cnt = 0;
    end

    // Absent part: the board pull-down holds the data line low
    assign eedo = present ? eedo_q : 1'b0;

    task automatic commit(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d, input logic full);
        if (op == 2'h0 && a[7:6] == 2'h3) wen = 1'b1;
        else if (op == 2'h0 && a[7:6] == 2'h0) wen = 1'b0;
        else if (wen && op != 2'h2) begin
            for (int i = 0; i < 256; i++) begin
                if (op == 2'h1 && full && 8'(i) == a) mem[i] = d;
                if (op == 2'h3 && 8'(i) == a) mem[i] = 8'hFF;
                if (op == 2'h0 && a[7:6] == 2'h1 && full) mem[i] = d;
                if (op == 2'h0 && a[7:6] == 2'h2) mem[i] = 8'hFF;
            end
            prog_cnt = slow ? 150 : 12;
        end
    endtask : commit

    // Pins are registered by the controller, so sampling on clk sees clean edges
    always @(posedge clk) begin
        nsr = {sr[17:0], eedi};
        if (prog_cnt > 0) prog_cnt--;
        if (!eecs) begin
            if (cs_d && nbits == 5'h0B) commit(sr[9:8], sr[7:0], 8'h00, 1'b0);
            if (cs_d && nbits == 5'h13) commit(sr[17:16], sr[15:8], sr[7:0], 1'b1);
            nbits = '0;
            rd = 1'b0;
            ridx = '0;
            // Deselected part floats its output, so the board pull-down wins
            eedo_q = 1'b0;
        end else if (eesk && !sk_d) begin
            if (rd) begin
                eedo_q = mem[rda][3'h7 - ridx];
                ridx++;
            end else if ((nbits != 0 || eedi) && nbits < 5'h13) begin
                sr = nsr;
                nbits++;
                if (nbits == 5'h0B && nsr[9:8] == 2'h2) begin
                    rd = 1'b1;
                    rda = nsr[7:0];
                end
            end
        end else if (nbits == 0) eedo_q = (prog_cnt == 0);
        sk_d = eesk;
        cs_d = eecs;
    end
endmodule : eecc_mem_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import eecc_pkg::*;
    localparam int TMO   = 200;
    localparam int LIMIT = 60000;

    typedef struct {eecc_op_t op; logic [7:0] a; logic [7:0] d; logic [7:0] ra; logic [7:0] ex;} eecc_row_t;

    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] mac_addr;
    logic        eecs, eesk, eedi, eedo, present, slow, se;
    int          err_count, checks_done, n, t0;
    int          cyc = 0;
    eecc_row_t   rows [8] = '{
        '{EECC_OP_EWEN,  8'h00, 8'h00, 8'h30, 8'h6A},
        '{EECC_OP_WRITE, 8'h30, 8'hC3, 8'h30, 8'hC3},
        '{EECC_OP_ERASE, 8'h30, 8'h00, 8'h30, 8'hFF},
        '{EECC_OP_WRITE, 8'h31, 8'h3C, 8'h31, 8'h3C},
        '{EECC_OP_WRAL,  8'h00, 8'h96, 8'h7F, 8'h96},
        '{EECC_OP_ERAL,  8'h00, 8'h00, 8'h31, 8'hFF},
        '{EECC_OP_EWDS,  8'h00, 8'h00, 8'h31, 8'hFF},
        '{EECC_OP_WRITE, 8'h31, 8'h11, 8'h31, 8'hFF}};

    eecc_top #(.TMO_CYC(TMO)) DUT (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .mac_addr(mac_addr), .eecs(eecs), .eesk(eesk), .eedi(eedi), .eedo(eedo));
    eecc_mem_model u_mem (.clk(clk), .eecs(eecs), .eesk(eesk), .eedi(eedi), .eedo(eedo), .present(present),
        .slow(slow));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            $display("FAIL %0t run limit reached", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
            err_count++;
        end
    endtask : chk

    // Entered right after a rising edge; leaves one idle cycle so strobes never toggle twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ends once pready is high; if pready never rises, only the run limit ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wait_idle();
        n = 0;
        do begin
            apb(1'b0, EECC_CMD_OFS, 32'h0);
            n++;
        end while (rd[EECC_BUSY_BIT] === 1'b1 && n < 3000);
        chk({31'h0, rd[EECC_BUSY_BIT]}, 32'h0, "busy clears");
    endtask : wait_idle

    task automatic cmd(input eecc_op_t op, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, EECC_DATA_OFS, {24'h0, d});
        apb(1'b1, EECC_CMD_OFS, {1'b1, op, 20'h0, a});
        apb(1'b0, EECC_CMD_OFS, 32'h0);
        chk({31'h0, rd[EECC_BUSY_BIT]}, 32'h1, "busy after start");
    endtask : cmd

    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        {sys_rst, present, slow} = 3'h6;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, EECC_CMD_OFS, 32'h0);
        chk({31'h0, rd[EECC_BUSY_BIT]}, 32'h1, "busy after reset");
        wait_idle();
        chk(mac_addr[31:0], 32'h5958_5B5A, "loaded address low");
        chk({16'h0, mac_addr[47:32]}, 32'h0000_5F5E, "loaded address high");
        apb(1'b0, EECC_MACL_OFS, 32'h0);
        chk(rd, 32'h5958_5B5A, "address register");
        apb(1'b0, EECC_MASK_OFS, 32'h0);
        chk(rd, 32'h0, "mask reset");
        apb(1'b0, 8'hA0, 32'h0);
        chk({rd[30:0], se}, 32'h1, "unmapped read");
        // A second read while busy must be refused, as must the data write
        cmd(EECC_OP_READ, 8'h02, 8'h00);
        apb(1'b1, EECC_CMD_OFS, {1'b1, EECC_OP_READ, 20'h0, 8'h03});
        apb(1'b1, EECC_DATA_OFS, 32'h77);
        wait_idle();
        chk({24'h0, rd[7:0]}, 32'h0000_0002, "refused command kept out");
        apb(1'b0, EECC_DATA_OFS, 32'h0);
        chk(rd, 32'h58, "read data kept");
        apb(1'b0, EECC_STS_OFS, 32'h0);
        chk(rd & 32'h3, 32'h1, "done status");
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, EECC_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, EECC_STS_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        foreach (rows[i]) begin
            slow <= (rows[i].op == EECC_OP_WRITE);
            cmd(rows[i].op, rows[i].a, rows[i].d);
            wait_idle();
            apb(1'b0, EECC_STS_OFS, 32'h0);
            chk(rd & 32'h3, 32'h1, "status after command");
            apb(1'b1, EECC_STS_OFS, 32'h3);
            cmd(EECC_OP_READ, rows[i].ra, 8'h00);
            wait_idle();
            apb(1'b0, EECC_DATA_OFS, 32'h0);
            chk(rd, {24'h0, rows[i].ex}, "read back");
        end
        present <= 1'b0;
        cmd(EECC_OP_WRITE, 8'h10, 8'h55);
        t0 = cyc;
        wait_idle();
        chk(32'(cyc - t0 > EECC_FRM_W * 2 * EECC_HALF_CYC + TMO - 60), 32'h1, "busy held until time-out");
        apb(1'b0, EECC_STS_OFS, 32'h0);
        chk({31'h0, rd[EECC_STS_TMO]}, 32'h1, "time-out status");
        present <= 1'b1;
        cmd(EECC_OP_RELOAD, 8'h00, 8'h00);
        wait_idle();
        chk({16'h0, mac_addr[47:32]}, 32'h0000_FFFF, "reloaded address");
        cmd(EECC_OP_READ, 8'h05, 8'h00);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, EECC_CMD_OFS, 32'h0);
        chk({31'h0, rd[EECC_BUSY_BIT]}, 32'h1, "busy after second reset");
        wait_idle();
        chk(mac_addr[31:0], 32'hFFFF_FFFF, "address after second reset");
        results();
    end
endmodule : testbench

// [pkg/eecc_pkg.sv]
package eecc_pkg;
    // Register byte offsets
    localparam logic [7:0]  EECC_CMD_OFS    = 8'hB0;
    localparam logic [7:0]  EECC_DATA_OFS   = 8'hB4;
    localparam logic [7:0]  EECC_STS_OFS    = 8'hB8;
    localparam logic [7:0]  EECC_MASK_OFS   = 8'hBC;
    localparam logic [7:0]  EECC_MACL_OFS   = 8'hC0;
    localparam logic [7:0]  EECC_MACH_OFS   = 8'hC4;
    // Command register fields
    localparam int          EECC_BUSY_BIT   = 31;
    localparam int          EECC_CMD_HI     = 30;
    localparam int          EECC_CMD_LO     = 28;
    localparam int          EECC_ADDR_W     = 8;
    localparam int          EECC_DATA_W     = 8;
    // Status and mask fields
    localparam int          EECC_STS_W      = 2;
    localparam int          EECC_STS_DONE   = 0;
    localparam int          EECC_STS_TMO    = 1;
    localparam logic [1:0]  EECC_STS_RST    = 2'h0;
    localparam logic [1:0]  EECC_MASK_RST   = 2'h0;
    // Automatic load of the station address
    localparam int          EECC_MAC_BYTES  = 6;
    // Serial frame: start bit, two opcode bits, address, data
    localparam int          EECC_FRM_W      = 19;
    localparam logic [4:0]  EECC_LEN_HDR    = 5'h0B;
    localparam logic [4:0]  EECC_LEN_DATA   = 5'h13;
    localparam logic [4:0]  EECC_LEN_RD     = 5'h08;

    typedef enum logic [2:0] {
        EECC_OP_READ   = 3'h0,
        EECC_OP_EWDS   = 3'h1,
        EECC_OP_EWEN   = 3'h2,
        EECC_OP_WRITE  = 3'h3,
        EECC_OP_WRAL   = 3'h4,
        EECC_OP_ERASE  = 3'h5,
        EECC_OP_ERAL   = 3'h6,
        EECC_OP_RELOAD = 3'h7
    } eecc_op_t;

    // Timing
    localparam longint      EECC_CLK_HZ     = 40000000;
    localparam longint      EECC_SK_HZ      = 1000000;
    localparam int          EECC_HALF_CYC   = int'(EECC_CLK_HZ / (2 * EECC_SK_HZ));
    localparam longint      EECC_TMO_US     = 30000;
    localparam int          EECC_TMO_CYC    = int'(EECC_TMO_US * EECC_CLK_HZ / 1000000);
endpackage : eecc_pkg

// [rtl/eecc_serial.sv]
`timescale 1ns/1ps
module eecc_serial
    import eecc_pkg::*;
#(
    parameter int TMO_CYC = EECC_TMO_CYC
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Request
    input  wire logic                   start,
    input  wire eecc_op_t               op,
    input  wire logic [EECC_ADDR_W-1:0] addr,
    input  wire logic [EECC_DATA_W-1:0] wdata,
    // Answer
    output logic                        done,
    output logic                        timed_out,
    output logic [EECC_DATA_W-1:0]      rdata,
    // Serial pins; din already synchronised
    output logic                        eecs,
    output logic                        eesk,
    output logic                        eedi,
    input  wire logic                   din
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_SEND = 5'b00010,
        S_RECV = 5'b00100,
        S_GAP  = 5'b01000,
        S_POLL = 5'b10000
    } eecc_ser_t;

    eecc_ser_t              st_r, st_nxt;
    logic [7:0]             div_r, div_nxt;
    logic                   sk_r, sk_nxt, cs_r, cs_nxt, done_r, done_nxt, to_r, to_nxt;
    logic [EECC_FRM_W-1:0]  sh_r, sh_nxt;
    logic [4:0]             cnt_r, cnt_nxt;
    logic [EECC_DATA_W-1:0] rd_r, rd_nxt;
    logic [31:0]            tmo_r, tmo_nxt;
    logic                   tick;

    function automatic logic [EECC_FRM_W-1:0] frame(eecc_op_t o, logic [7:0] a, logic [7:0] d);
        case (o)
            EECC_OP_WRITE: frame = {3'h5, a, d};
            EECC_OP_ERASE: frame = {3'h7, a, 8'h00};
            EECC_OP_EWEN:  frame = {3'h4, 8'hC0, 8'h00};
            EECC_OP_EWDS:  frame = {3'h4, 8'h00, 8'h00};
            EECC_OP_WRAL:  frame = {3'h4, 8'h40, d};
            EECC_OP_ERAL:  frame = {3'h4, 8'h80, 8'h00};
            default:       frame = {3'h6, a, 8'h00};
        endcase
    endfunction : frame

    function automatic logic polls(eecc_op_t o);
        polls = (o == EECC_OP_WRITE) || (o == EECC_OP_WRAL) || (o == EECC_OP_ERASE) || (o == EECC_OP_ERAL);
    endfunction : polls

    eecc_op_t op_r, op_nxt;

    // The bit divider is eight bits wide
    if (TMO_CYC < 2 || EECC_HALF_CYC < 1 || EECC_HALF_CYC > 256) begin : g_bad_timing
        $error("eecc_serial: timing parameters out of range");
    end

    assign tick = (div_r == 8'(EECC_HALF_CYC - 1));

    always_comb begin
        st_nxt   = st_r;
        div_nxt  = tick ? 8'h00 : div_r + 8'h01;
        sk_nxt   = sk_r;
        cs_nxt   = cs_r;
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        rd_nxt   = rd_r;
        tmo_nxt  = tmo_r;
        op_nxt   = op_r;
        done_nxt = 1'b0;
        to_nxt   = 1'b0;
        case (st_r)
            S_IDLE: begin
                div_nxt = 8'h00;
                if (start) begin
                    sh_nxt  = frame(op, addr, wdata);
                    cnt_nxt = (op == EECC_OP_WRITE || op == EECC_OP_WRAL) ? EECC_LEN_DATA : EECC_LEN_HDR;
                    op_nxt  = op;
                    cs_nxt  = 1'b1;
                    st_nxt  = S_SEND;
                end
            end
            S_SEND: if (tick) begin
                sk_nxt = ~sk_r;
                if (sk_r) begin
                    sh_nxt  = {sh_r[EECC_FRM_W-2:0], 1'b0};
                    cnt_nxt = cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        if (op_r == EECC_OP_READ || op_r == EECC_OP_RELOAD) begin
                            cnt_nxt = EECC_LEN_RD;
                            st_nxt  = S_RECV;
                        end else begin
                            cs_nxt   = 1'b0;
                            st_nxt   = polls(op_r) ? S_GAP : S_IDLE;
                            done_nxt = !polls(op_r);
                        end
                    end
                end
            end
            S_RECV: if (tick) begin
                sk_nxt = ~sk_r;
                if (sk_r) begin
                    rd_nxt  = {rd_r[EECC_DATA_W-2:0], din};
                    cnt_nxt = cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        cs_nxt   = 1'b0;
                        done_nxt = 1'b1;
                        st_nxt   = S_IDLE;
                    end
                end
            end
            S_GAP: if (tick) begin
                cs_nxt  = 1'b1;
                tmo_nxt = 32'h0;
                st_nxt  = S_POLL;
            end
            S_POLL: begin
                tmo_nxt = tmo_r + 32'h1;
                // A missing part never raises ready; only the time-out ends the wait
                if (din || tmo_r == 32'(TMO_CYC - 1)) begin
                    cs_nxt   = 1'b0;
                    done_nxt = 1'b1;
                    to_nxt   = !din;
                    st_nxt   = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r   <= S_IDLE;
            div_r  <= 8'h00;
            sk_r   <= 1'b0;
            cs_r   <= 1'b0;
            sh_r   <= '0;
            cnt_r  <= 5'h00;
            rd_r   <= '0;
            tmo_r  <= 32'h0;
            op_r   <= EECC_OP_READ;
            done_r <= 1'b0;
            to_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            div_r  <= div_nxt;
            sk_r   <= sk_nxt;
            cs_r   <= cs_nxt;
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            rd_r   <= rd_nxt;
            tmo_r  <= tmo_nxt;
            op_r   <= op_nxt;
            done_r <= done_nxt;
            to_r   <= to_nxt;
        end
    end

    assign done      = done_r;
    assign timed_out = to_r;
    assign rdata     = rd_r;
    assign eecs      = cs_r;
    assign eesk      = sk_r;
    assign eedi      = sh_r[EECC_FRM_W-1];
endmodule : eecc_serial

// [rtl/eecc_top.sv]
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Writing one to bit 31 starts the selected command at the given address.
// - Busy bit 31 stays set for the whole operation, cleared only when done.
// - For a read, busy clears only once the data register holds the word.
// - Write with no memory present stays busy until time-out, then clears.
// - Busy reads as set straight after reset, the address load being underway.
// - Busy clears after the automatic address load, successful or merely attempted.
module eecc_top
    import eecc_pkg::*;
#(
    parameter int TMO_CYC = EECC_TMO_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt and loaded station address
    output logic             irq,
    output logic      [47:0] mac_addr,
    // Serial memory pins
    output logic             eecs,
    output logic             eesk,
    output logic             eedi,
    input  wire logic        eedo
);
    typedef enum logic [2:0] {
        T_BOOT = 3'b001,
        T_IDLE = 3'b010,
        T_RUN  = 3'b100
    } eecc_top_t;

    eecc_top_t              st_r, st_nxt;
    logic                   busy_r, busy_nxt, start_r, start_nxt, irq_r, irq_nxt;
    eecc_op_t               cmd_r, cmd_nxt;
    logic [EECC_ADDR_W-1:0] addr_r, addr_nxt;
    logic [EECC_DATA_W-1:0] data_r, data_nxt;
    logic [EECC_STS_W-1:0]  sts_r, sts_nxt, mask_r, mask_nxt;
    logic [47:0]            mac_r, mac_nxt;
    logic [2:0]             idx_r, idx_nxt;
    logic [31:0]            prdata_r, prdata_nxt;
    logic                   pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [2:0]             sync_r;
    logic                   din_r, din_nxt;
    logic                   eng_done, eng_to;
    logic [EECC_DATA_W-1:0] eng_rdata;
    logic                   wr_acc, rd_acc, cmd_go;

    function automatic logic mapped(logic [7:0] a);
        mapped = (a == EECC_CMD_OFS) || (a == EECC_DATA_OFS) || (a == EECC_STS_OFS) ||
                 (a == EECC_MASK_OFS) || (a == EECC_MACL_OFS) || (a == EECC_MACH_OFS);
    endfunction : mapped

    // Writes act on the second access cycle, when pready is already high; reads are captured on the first, while pready is low
    assign wr_acc = psel && penable && pready_r && pwrite;
    assign rd_acc = psel && penable && !pready_r && !pwrite;
    assign cmd_go = wr_acc && paddr == EECC_CMD_OFS && pwdata[EECC_BUSY_BIT] && !busy_r;

    eecc_serial #(
        .TMO_CYC   (TMO_CYC)
    ) u_seq (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .start     (start_r),
        .op        (st_r == T_BOOT ? EECC_OP_READ : cmd_r),
        .addr      (st_r == T_BOOT ? 8'(idx_r) : addr_r),
        .wdata     (data_r),
        .done      (eng_done),
        .timed_out (eng_to),
        .rdata     (eng_rdata),
        .eecs      (eecs),
        .eesk      (eesk),
        .eedi      (eedi),
        .din       (din_r)
    );

    // Data-out pin: three stages, a change counts once the last two agree
    assign din_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : din_r;

    always_comb begin
        st_nxt      = st_r;
        busy_nxt    = busy_r;
        start_nxt   = 1'b0;
        cmd_nxt     = cmd_r;
        addr_nxt    = addr_r;
        data_nxt    = data_r;
        mac_nxt     = mac_r;
        idx_nxt     = idx_r;
        sts_nxt     = sts_r;
        mask_nxt    = mask_r;
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = psel && penable && !pready_r && !mapped(paddr);
        prdata_nxt  = 32'h0;
        if (rd_acc) begin
            case (paddr)
                EECC_CMD_OFS:  prdata_nxt = {busy_r, cmd_r, 20'h0, addr_r};
                EECC_DATA_OFS: prdata_nxt = {24'h0, data_r};
                EECC_STS_OFS:  prdata_nxt = {30'h0, sts_r};
                EECC_MASK_OFS: prdata_nxt = {30'h0, mask_r};
                EECC_MACL_OFS: prdata_nxt = mac_r[31:0];
                EECC_MACH_OFS: prdata_nxt = {16'h0, mac_r[47:32]};
                default:       prdata_nxt = 32'h0;
            endcase
        end
        // Writes to command and data are dropped while busy, so a running frame never changes under us
        if (wr_acc && !busy_r && paddr == EECC_DATA_OFS) data_nxt = pwdata[EECC_DATA_W-1:0];
        if (wr_acc && paddr == EECC_MASK_OFS) mask_nxt = pwdata[EECC_STS_W-1:0];
        if (wr_acc && paddr == EECC_STS_OFS) sts_nxt = sts_r & ~pwdata[EECC_STS_W-1:0];
        case (st_r)
            T_BOOT: begin
                if (eng_done) begin
                    mac_nxt[8*idx_r +: 8] = eng_rdata;
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r == 3'(EECC_MAC_BYTES - 1)) begin
                        busy_nxt = 1'b0;
                        st_nxt   = T_IDLE;
                    end else begin
                        start_nxt = 1'b1;
                    end
                end
            end
            T_IDLE: begin
                if (cmd_go) begin
                    cmd_nxt  = eecc_op_t'(pwdata[EECC_CMD_HI:EECC_CMD_LO]);
                    addr_nxt = pwdata[EECC_ADDR_W-1:0];
                    busy_nxt = 1'b1;
                    start_nxt = 1'b1;
                    idx_nxt  = 3'h0;
                    st_nxt   = (pwdata[EECC_CMD_HI:EECC_CMD_LO] == EECC_OP_RELOAD) ? T_BOOT : T_RUN;
                end
            end
            T_RUN: begin
                // Busy holds until the serial engine reports the frame finished
                if (eng_done) begin
                    if (cmd_r == EECC_OP_READ) data_nxt = eng_rdata;
                    busy_nxt = 1'b0;
                    st_nxt   = T_IDLE;
                end
            end
            default: st_nxt = T_IDLE;
        endcase
        // Hardware set beats a same-cycle software clear
        if (eng_done && st_r == T_RUN) sts_nxt[EECC_STS_DONE] = 1'b1;
        if (eng_to && st_r == T_RUN) sts_nxt[EECC_STS_TMO] = 1'b1;
        irq_nxt = |(sts_r & mask_r);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r      <= T_BOOT;
            busy_r    <= 1'b1;
            start_r   <= 1'b1;
            cmd_r     <= EECC_OP_READ;
            addr_r    <= '0;
            data_r    <= '0;
            mac_r     <= 48'h0;
            idx_r     <= 3'h0;
            sts_r     <= EECC_STS_RST;
            mask_r    <= EECC_MASK_RST;
            irq_r     <= 1'b0;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            sync_r    <= 3'h0;
            din_r     <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            busy_r    <= busy_nxt;
            start_r   <= start_nxt;
            cmd_r     <= cmd_nxt;
            addr_r    <= addr_nxt;
            data_r    <= data_nxt;
            mac_r     <= mac_nxt;
            idx_r     <= idx_nxt;
            sts_r     <= sts_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            sync_r    <= {sync_r[1:0], eedo};
            din_r     <= din_nxt;
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign irq      = irq_r;
    assign mac_addr = mac_r;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_busy_after_reset: assert property ($past(sys_rst) |-> busy_r && st_r == T_BOOT)
        else $error("busy not set after reset");
    a_start_sets_busy: assert property (cmd_go |=> busy_r && start_r)
        else $error("command start did not raise busy");
    a_busy_holds_run: assert property (busy_r && !eng_done |=> busy_r)
        else $error("busy dropped before completion");
    a_busy_falls_done: assert property ($fell(busy_r) |-> $past(eng_done))
        else $error("busy fell without completion");
    a_read_data_ready: assert property (st_r == T_RUN && eng_done && cmd_r == EECC_OP_READ
        |=> !busy_r && data_r == $past(eng_rdata))
        else $error("read data not in place when busy cleared");
    a_cmd_locked_busy: assert property (busy_r && wr_acc |=> $stable(cmd_r) && $stable(addr_r))
        else $error("command changed while busy");
    a_timeout_clears: assert property (st_r == T_RUN && eng_to |=> !busy_r && sts_r[EECC_STS_TMO])
        else $error("time-out did not end the operation");
    a_boot_load_end: assert property (st_r == T_BOOT && eng_done && idx_r == 3'(EECC_MAC_BYTES - 1)
        |=> !busy_r ##0 st_r == T_IDLE ##0 mac_r[47:40] == $past(eng_rdata))
        else $error("address load did not clear busy");
    a_cmd_field_read: assert property (rd_acc && paddr == EECC_CMD_OFS
        |=> prdata_r[EECC_CMD_HI:EECC_CMD_LO] == $past(cmd_r) && prdata_r[EECC_BUSY_BIT] == $past(busy_r))
        else $error("command field misplaced");
    a_irq_follows: assert property (|(sts_r & mask_r) ##1 |(sts_r & mask_r) |-> irq_r)
        else $error("interrupt not raised");

    c_read_done: cover property (st_r == T_RUN && cmd_r == EECC_OP_READ && eng_done);
    c_write_tmo: cover property (st_r == T_RUN && eng_to);
    c_boot_done: cover property ($fell(busy_r) && st_r == T_IDLE);
    c_irq_high: cover property ($rose(irq_r));
endmodule : eecc_top
